// *** pulse_meter_pkg.sv ***
// Shared constants, register map and state encoding of the pulse width meter.
`default_nettype none

package pulse_meter_pkg;

  // ==========================================================================
  // Timing.
  localparam int unsigned PCLK_HZ         = 250_000_000;
  localparam int unsigned COUNT_HZ        = 10_000_000;
  localparam int unsigned COUNT_DIV       = PCLK_HZ / COUNT_HZ;
  localparam int unsigned COUNT_PERIOD_NS = 1_000_000_000 / COUNT_HZ;

  // ==========================================================================
  // Counter and tally limits.
  localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
  localparam logic [15:0] TALLY_MAX   = 16'hFFFF;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] STATUS_OFFSET     = 8'h04;
  localparam logic [7:0] COUNTER_OFFSET    = 8'h08;
  localparam logic [7:0] CAPTURE_OFFSET    = 8'h0C;
  localparam logic [7:0] TALLY_OFFSET      = 8'h10;
  localparam logic [7:0] WIDTH_LO_OFFSET   = 8'h14;
  localparam logic [7:0] WIDTH_HI_OFFSET   = 8'h18;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h1C;
  localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h20;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h24;

  // ==========================================================================
  // Field positions.
  localparam int CTRL_RUN_BIT       = 0;
  localparam int STAT_MEASURING_BIT = 0;
  localparam int STAT_FAULT_BIT     = 1;
  localparam int STAT_BUSY_BIT      = 2;
  localparam int STAT_CAP_PEND_BIT  = 3;
  localparam int STAT_OVF_PEND_BIT  = 4;
  localparam int STAT_PIN_BIT       = 5;
  localparam int IRQ_CAPTURE_BIT    = 0;
  localparam int IRQ_OVERFLOW_BIT   = 1;
  localparam int IRQ_WIDTH_BIT      = 2;
  localparam int IRQ_ERROR_BIT      = 3;
  localparam int IRQ_W              = 4;
  localparam int WIDTH_W            = 40;

  // ==========================================================================
  // Reset values.
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 4'h0;
  localparam logic             RUN_RESET        = 1'b0;

  // ==========================================================================
  // Event handler states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OVF  = 3'b001,
    ST_CAP  = 3'b010,
    ST_CALC = 3'b011,
    ST_HALT = 3'b100
  } handler_state_type;

endpackage

`default_nettype wire

// *** pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter and edge pulse.
`default_nettype none

module pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_async,
  output logic      level,
  output logic      edge_pulse
);

  logic meta_q;
  logic sync2_q;
  logic sync3_q;
  logic level_q;
  logic edge_q;

  // ==========================================================================
  // Synchroniser chain; the first stage feeds only the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q  <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      meta_q  <= pin_async;
      sync2_q <= meta_q;
      sync3_q <= sync2_q;
    end
  end

  // A change counts once the second and third stages agree on it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      edge_q  <= 1'b0;
    end else begin
      edge_q <= 1'b0;
      if ((sync2_q == sync3_q) && (sync3_q != level_q)) begin
        level_q <= sync3_q;
        edge_q  <= 1'b1;
      end
    end
  end

  assign level      = level_q;
  assign edge_pulse = edge_q;

endmodule

`default_nettype wire

// *** pulse_high_width_meter.sv ***
// Pulse high width meter: timer, capture, event handler and APB registers.
//
// Notes on behaviour
// - Edge at counter FFFFh captures FFFFh, clears counter, raises capture.
// - Wrap coinciding with capture clear: clear wins, no overflow event.
// - Overflow tally counts overflow events only while measuring.
// - Tally passing 65,535 during measurement enters the error state.
// - Error state drives error output and halts until reset.
// - Capture with pin low computes width and clears measuring flag in the same cycle.
// - Measuring flag: 0 idle, 1 high-width measurement running.
// - Fault flag: 0 normal, 1 error.
// - Tally, counter, width, measuring and fault are initialised first.
// - Captured FFFFh at falling edge is used whole with unchanged tally.
// - Edge during busy handling still captures and leaves capture pending.
// - Pending overflow is handled before pending capture.
// - Both pin edges capture the counter and clear it.
// - Capture with pin high sets measuring and clears the tally.
// - Width is period times (tally times 10000h plus capture).
// - Counter advances at 10 MHz, about 100 ns per count.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`default_nettype none

module pulse_high_width_meter #(
  parameter int unsigned COUNT_DIV = pulse_meter_pkg::COUNT_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pulse_input_pin,
  output logic             error_output_port,
  output logic             irq
);

  localparam int DIV_W = (COUNT_DIV < 2) ? 1 : $clog2(COUNT_DIV);
  localparam int IW    = pulse_meter_pkg::IRQ_W;
  localparam int WW    = pulse_meter_pkg::WIDTH_W;

  // ==========================================================================
  // Elaboration check.
  if (COUNT_DIV < 2) begin : g_bad_div
    $error("COUNT_DIV must be at least 2");
  end

  // ==========================================================================
  // Declarations.
  logic                  pin_level;
  logic                  pin_edge;
  logic                  run_q;
  logic [DIV_W-1:0]      div_q;
  logic                  count_tick;
  logic [15:0]           timer_counter_q;
  logic [15:0]           capture_register_q;
  logic                  capture_level_q;
  logic                  capture_event;
  logic                  overflow_event;
  logic                  cap_pend_q;
  logic                  ovf_pend_q;
  logic [15:0]           overflow_tally_q;
  logic [31:0]           snap_counts_q;
  logic [WW-1:0]         width_q;
  logic                  measuring_q;
  logic                  fault_q;
  pulse_meter_pkg::handler_state_type state_q;
  logic                  take_ovf;
  logic                  take_cap;
  logic                  active;
  logic                  start_pulse;
  logic                  wr_en;
  logic                  setup;
  logic                  addr_ok;
  logic                  width_done;
  logic                  error_enter;
  logic [IW-1:0]         irq_status_q;
  logic [IW-1:0]         irq_enable_q;
  logic [IW-1:0]         irq_events;
  logic [IW-1:0]         irq_clear;
  logic [31:0]           rd_value;
  logic [31:0]           prdata_q;
  logic                  pslverr_q;

  // ==========================================================================
  // Pin synchroniser.
  pin_sync u_pin_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_async  (pulse_input_pin),
    .level      (pin_level),
    .edge_pulse (pin_edge)
  );

  // ==========================================================================
  // APB decode. The slave always answers in the first access cycle.
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // Writing run with a rising value starts a fresh measurement session.
  assign start_pulse = wr_en && (paddr == pulse_meter_pkg::CTRL_OFFSET) &&
                       pwdata[pulse_meter_pkg::CTRL_RUN_BIT] && !run_q &&
                       !fault_q;

  // The block only measures while running and free of faults.
  assign active = run_q && !fault_q;

  // Control register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= pulse_meter_pkg::RUN_RESET;
    end else if (wr_en && (paddr == pulse_meter_pkg::CTRL_OFFSET)) begin
      run_q <= pwdata[pulse_meter_pkg::CTRL_RUN_BIT];
    end
  end

  // ==========================================================================
  // Count-rate prescaler: one tick every COUNT_DIV clocks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (!active || start_pulse) begin
      div_q <= '0;
    end else if (div_q == DIV_W'(COUNT_DIV - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  assign count_tick = active && (div_q == DIV_W'(COUNT_DIV - 1));

  // ==========================================================================
  // Capture on either pin edge; overflow only when no clear competes.
  assign capture_event  = active && pin_edge;
  assign overflow_event = count_tick && !capture_event &&
                          (timer_counter_q == pulse_meter_pkg::COUNTER_MAX);

  // Timer counter: cleared by capture, otherwise advances on tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_counter_q <= 16'h0000;
    end else if (start_pulse || capture_event) begin
      timer_counter_q <= 16'h0000;
    end else if (count_tick) begin
      timer_counter_q <= timer_counter_q + 16'h0001;
    end
  end

  // Capture register takes the counter value even while handling is busy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_register_q <= 16'h0000;
      capture_level_q    <= 1'b0;
    end else if (start_pulse) begin
      capture_register_q <= 16'h0000;
      capture_level_q    <= 1'b0;
    end else if (capture_event) begin
      capture_register_q <= timer_counter_q;
      capture_level_q    <= pin_level;
    end
  end

  // ==========================================================================
  // Pending events; a new event in the taking cycle stays pending.
  assign take_ovf = (state_q == pulse_meter_pkg::ST_IDLE) && ovf_pend_q;
  assign take_cap = (state_q == pulse_meter_pkg::ST_IDLE) && !ovf_pend_q &&
                    cap_pend_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_pend_q <= 1'b0;
      ovf_pend_q <= 1'b0;
    end else if (start_pulse || fault_q) begin
      cap_pend_q <= 1'b0;
      ovf_pend_q <= 1'b0;
    end else begin
      if (capture_event) begin
        cap_pend_q <= 1'b1;
      end else if (take_cap) begin
        cap_pend_q <= 1'b0;
      end
      if (overflow_event) begin
        ovf_pend_q <= 1'b1;
      end else if (take_ovf) begin
        ovf_pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Event handler state machine.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pulse_meter_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        pulse_meter_pkg::ST_IDLE: begin
          if (take_ovf) begin
            state_q <= pulse_meter_pkg::ST_OVF;
          end else if (take_cap) begin
            state_q <= pulse_meter_pkg::ST_CAP;
          end
        end
        pulse_meter_pkg::ST_OVF: begin
          if (error_enter) begin
            state_q <= pulse_meter_pkg::ST_HALT;
          end else begin
            state_q <= pulse_meter_pkg::ST_IDLE;
          end
        end
        pulse_meter_pkg::ST_CAP: begin
          if (!capture_level_q && measuring_q) begin
            state_q <= pulse_meter_pkg::ST_CALC;
          end else begin
            state_q <= pulse_meter_pkg::ST_IDLE;
          end
        end
        pulse_meter_pkg::ST_CALC: state_q <= pulse_meter_pkg::ST_IDLE;
        pulse_meter_pkg::ST_HALT: state_q <= pulse_meter_pkg::ST_HALT;
        default:                  state_q <= pulse_meter_pkg::ST_IDLE;
      endcase
    end
  end

  assign error_enter = (state_q == pulse_meter_pkg::ST_OVF) && measuring_q &&
                       (overflow_tally_q == pulse_meter_pkg::TALLY_MAX);
  assign width_done  = (state_q == pulse_meter_pkg::ST_CALC);

  // Overflow tally: counts while measuring, restarts on a rising capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_tally_q <= 16'h0000;
    end else if (start_pulse) begin
      overflow_tally_q <= 16'h0000;
    end else if ((state_q == pulse_meter_pkg::ST_OVF) && measuring_q &&
                 !error_enter) begin
      overflow_tally_q <= overflow_tally_q + 16'h0001;
    end else if ((state_q == pulse_meter_pkg::ST_CAP) && capture_level_q) begin
      overflow_tally_q <= 16'h0000;
    end
  end

  // Measuring flag: 1 while a high phase is timed, 0 otherwise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      measuring_q <= 1'b0;
    end else if (start_pulse) begin
      measuring_q <= 1'b0;
    end else if ((state_q == pulse_meter_pkg::ST_CAP) && capture_level_q) begin
      measuring_q <= 1'b1;
    end else if (width_done) begin
      measuring_q <= 1'b0;
    end
  end

  // Fault flag: 1 after the tally limit is passed, held until reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (error_enter) begin
      fault_q <= 1'b1;
    end
  end

  assign error_output_port = fault_q;

  // Snapshot of tally and capture taken when the capture is handled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_counts_q <= 32'h0000_0000;
    end else if (state_q == pulse_meter_pkg::ST_CAP) begin
      snap_counts_q <= {overflow_tally_q, capture_register_q};
    end
  end

  // Width in nanoseconds from the snapshot.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_q <= '0;
    end else if (start_pulse) begin
      width_q <= '0;
    end else if (width_done) begin
      width_q <= WW'(snap_counts_q) *
                 WW'(pulse_meter_pkg::COUNT_PERIOD_NS);
    end
  end

  // ==========================================================================
  // Interrupts: sticky status, write-one clear, enable mask.
  assign irq_events = {error_enter, width_done, overflow_event, capture_event};
  assign irq_clear  = (wr_en && (paddr == pulse_meter_pkg::IRQ_CLEAR_OFFSET))
                      ? pwdata[IW-1:0] : '0;

  // A set in the clearing cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_q <= pulse_meter_pkg::IRQ_ENABLE_RESET;
    end else if (wr_en && (paddr == pulse_meter_pkg::IRQ_ENABLE_OFFSET)) begin
      irq_enable_q <= pwdata[IW-1:0];
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // ==========================================================================
  // Read multiplexer, evaluated in the setup cycle.
  always_comb begin
    rd_value = 32'h0000_0000;
    addr_ok  = 1'b1;
    unique case (paddr)
      pulse_meter_pkg::CTRL_OFFSET: begin
        rd_value[pulse_meter_pkg::CTRL_RUN_BIT] = run_q;
      end
      pulse_meter_pkg::STATUS_OFFSET: begin
        rd_value[pulse_meter_pkg::STAT_MEASURING_BIT] = measuring_q;
        rd_value[pulse_meter_pkg::STAT_FAULT_BIT]     = fault_q;
        rd_value[pulse_meter_pkg::STAT_BUSY_BIT]      =
          (state_q != pulse_meter_pkg::ST_IDLE);
        rd_value[pulse_meter_pkg::STAT_CAP_PEND_BIT]  = cap_pend_q;
        rd_value[pulse_meter_pkg::STAT_OVF_PEND_BIT]  = ovf_pend_q;
        rd_value[pulse_meter_pkg::STAT_PIN_BIT]       = pin_level;
      end
      pulse_meter_pkg::COUNTER_OFFSET:    rd_value[15:0] = timer_counter_q;
      pulse_meter_pkg::CAPTURE_OFFSET:    rd_value[15:0] = capture_register_q;
      pulse_meter_pkg::TALLY_OFFSET:      rd_value[15:0] = overflow_tally_q;
      pulse_meter_pkg::WIDTH_LO_OFFSET:   rd_value = width_q[31:0];
      pulse_meter_pkg::WIDTH_HI_OFFSET:   rd_value[WW-33:0] = width_q[WW-1:32];
      pulse_meter_pkg::IRQ_STATUS_OFFSET: rd_value[IW-1:0] = irq_status_q;
      pulse_meter_pkg::IRQ_CLEAR_OFFSET:  rd_value = 32'h0000_0000;
      pulse_meter_pkg::IRQ_ENABLE_OFFSET: rd_value[IW-1:0] = irq_enable_q;
      default:                            addr_ok = 1'b0;
    endcase
  end

  // Read data and error flag are registered in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr_q <= !addr_ok;
    end else if (!psel) begin
      pslverr_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** pulse_source_model.sv ***
// Behavioural pulse source that drives the meter's pulse input pin.
`default_nettype none

module pulse_source_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [15:0] high_len,
  output logic             level_q
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] left_q;

  // ==========================================================================
  // One high phase per start, then low; callers keep both phases long.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      left_q  <= 16'h0000;
    end else if (start && !level_q) begin
      level_q <= 1'b1;
      left_q  <= high_len;
    end else if (level_q && left_q <= 16'h0001) begin
      level_q <= 1'b0;
    end else if (level_q) begin
      left_q <= left_q - 16'h0001;
    end
  end
endmodule

`default_nettype wire

// *** pulse_meter_monitor.sv ***
// Port-level assertions for the pulse high width meter.
`default_nettype none

module pulse_meter_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pulse_input_pin,
  input wire logic        error_output_port,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       setup;
  logic       map_ok;
  logic [3:0] en_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Decoding of the setup phase and a shadow of the interrupt enables.
  assign setup  = psel && !penable;
  assign map_ok = paddr <= 8'h24 && paddr[1:0] == 2'b00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 4'h0;
    end else if (psel && penable && pwrite &&
                 paddr == pulse_meter_pkg::IRQ_ENABLE_OFFSET) begin
      en_q <= pwdata[3:0];
    end
  end

  // ==========================================================================
  // Assertions.
  a_unmapped_error :
    assert property (setup && !map_ok |=> pslverr && pready && prdata == 0)
    else $error("unmapped access not refused");
  a_mapped_clean :
    assert property (setup && map_ok |=> !pslverr)
    else $error("mapped access flagged as error");
  a_write_reads_zero :
    assert property (setup && pwrite |=> prdata == 32'h0)
    else $error("write returned nonzero read data");
  a_clear_reads_zero :
    assert property (setup && !pwrite &&
      paddr == pulse_meter_pkg::IRQ_CLEAR_OFFSET |=> prdata == 32'h0)
    else $error("clear register read nonzero");
  a_error_sticky :
    assert property ($rose(error_output_port) |=> error_output_port [*8])
    else $error("error output dropped before reset");
  a_fault_status :
    assert property (setup && !pwrite && error_output_port &&
      paddr == pulse_meter_pkg::STATUS_OFFSET |=> prdata[1])
    else $error("fault flag not shown while error output high");
  a_fault_tally_full :
    assert property (setup && !pwrite && error_output_port &&
      paddr == pulse_meter_pkg::TALLY_OFFSET |=> prdata[15:0] == 16'hFFFF)
    else $error("fault without full overflow tally");
  a_irq_masked :
    assert property (en_q == 4'h0 |-> !irq)
    else $error("interrupt raised with all enables off");
  a_reset_clean :
    assert property ($rose(presetn) |-> !error_output_port && !irq)
    else $error("outputs not cleared by reset");
  a_width_hi_range :
    assert property (setup && !pwrite &&
      paddr == pulse_meter_pkg::WIDTH_HI_OFFSET |=> prdata[31:8] == 0)
    else $error("upper width word wider than forty bits");

  // Main scenarios reached.
  c_irq : cover property ($rose(irq));
  c_unmapped : cover property (setup && !map_ok);
  c_pin_high : cover property ($rose(pulse_input_pin));
endmodule

`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench for the pulse high width meter.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        err_out;
  logic        irq;
  logic        go;
  logic [15:0] hlen;
  logic [31:0] q;
  logic        e;
  logic [31:0] cap;
  int          fail_count;
  int          checks;

  // ==========================================================================
  // Design with a short prescaler, and the pulse source beside it.
  pulse_high_width_meter #(.COUNT_DIV(2)) u_pulse_high_width_meter (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_input_pin(pin),
    .error_output_port(err_out), .irq(irq));

  pulse_source_model u_pulse_source_model (
    .pclk(pclk), .presetn(presetn), .start(go), .high_len(hlen),
    .level_q(pin));

  // Clock of 4 ns period.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for pready with no limit of its own; the watchdog ends a hang.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic [15:0] len);
    @(posedge pclk);
    hlen <= len;
    go   <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask

  // Polls until the width-done status bit shows; the watchdog bounds it.
  task automatic wait_width();
    do begin
      apb(1'b0, pulse_meter_pkg::IRQ_STATUS_OFFSET, 32'h0);
    end while (q[2] !== 1'b1);
  endtask

  // Judges one finished measurement of about the given tick count.
  task automatic check_width(input int ticks);
    apb(1'b0, pulse_meter_pkg::CAPTURE_OFFSET, 32'h0);
    cap = q;
    chk(32'(cap >= ticks - 1 && cap <= ticks + 1), 32'h1, "capture");
    apb(1'b0, pulse_meter_pkg::TALLY_OFFSET, 32'h0);
    chk(q, 32'h0, "tally");
    apb(1'b0, pulse_meter_pkg::WIDTH_LO_OFFSET, 32'h0);
    chk(q, cap * 100, "width low");
    apb(1'b0, pulse_meter_pkg::WIDTH_HI_OFFSET, 32'h0);
    chk(q, 32'h0, "width high");
    apb(1'b0, pulse_meter_pkg::STATUS_OFFSET, 32'h0);
    chk(q[0], 32'h0, "measuring after fall");
  endtask

  task automatic clear_irq();
    apb(1'b1, pulse_meter_pkg::IRQ_CLEAR_OFFSET, 32'hF);
    apb(1'b0, pulse_meter_pkg::IRQ_STATUS_OFFSET, 32'h0);
    chk(q, 32'h0, "status after clear");
    chk(irq, 32'h0, "irq after clear");
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    for (int a = 0; a <= 36; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(q, 32'h0, "reset value");
      chk(e, 32'h0, "reset access error");
    end
    chk(err_out, 32'h0, "error output at reset");
    $display("test reset done");
  endtask

  task automatic t_refuse();
    apb(1'b0, 8'h28, 32'h0);
    chk(e, 32'h1, "unmapped read error");
    chk(q, 32'h0, "unmapped read data");
    apb(1'b1, 8'h2A, 32'h5);
    chk(e, 32'h1, "unaligned write error");
    apb(1'b1, pulse_meter_pkg::CAPTURE_OFFSET, 32'h1234);
    apb(1'b0, pulse_meter_pkg::CAPTURE_OFFSET, 32'h0);
    chk(q, 32'h0, "read-only capture");
    $display("test refuse done");
  endtask

  task automatic t_measure();
    apb(1'b1, pulse_meter_pkg::IRQ_ENABLE_OFFSET, 32'hF);
    apb(1'b1, pulse_meter_pkg::CTRL_OFFSET, 32'h1);
    pulse(16'd40);
    repeat (15) @(posedge pclk);
    apb(1'b0, pulse_meter_pkg::STATUS_OFFSET, 32'h0);
    chk(q[0], 32'h1, "measuring while high");
    chk(irq, 32'h1, "capture irq on rise");
    wait_width();
    check_width(20);
    apb(1'b0, pulse_meter_pkg::IRQ_STATUS_OFFSET, 32'h0);
    chk(q, 32'h5, "capture and width events");
    clear_irq();
    $display("test measure done");
  endtask

  task automatic t_mask();
    apb(1'b1, pulse_meter_pkg::IRQ_ENABLE_OFFSET, 32'h0);
    pulse(16'd60);
    wait_width();
    chk(irq, 32'h0, "masked irq");
    apb(1'b1, pulse_meter_pkg::IRQ_ENABLE_OFFSET, 32'h4);
    check_width(30);
    chk(irq, 32'h1, "unmasked irq");
    clear_irq();
    $display("test mask done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog far beyond the expected run length.
  initial begin
    #40000;
    fail_count++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    go         = 1'b0;
    hlen       = 16'h0000;
    fail_count = 0;
    checks     = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_refuse();
    t_measure();
    t_mask();
    report_and_stop();
  end
endmodule

bind pulse_high_width_meter pulse_meter_monitor u_pulse_meter_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pulse_input_pin(pulse_input_pin),
  .error_output_port(error_output_port), .irq(irq));

`default_nettype wire
